// File: hdl/bdal_pkg.sv
/*
  Shared constants and carrier types for the branch, delay-slot, add and
  logic-op execute block.
  Assumes a one-instruction-per-cycle core with a 32-bit instruction word.
*/
`default_nettype none
package bdal_pkg;
  // Major opcodes
  localparam logic [5:0] REG_FORMAT_MAJOR_OP = 6'h00;
  localparam logic [5:0] OP_SUM_IMM_WITH_TRAP = 6'h08;
  localparam logic [5:0] OP_SUM_IMM_NO_TRAP = 6'h09;
  localparam logic [5:0] OP_MASK_WITH_IMM = 6'h0c;
  localparam logic [3:0] COP_MAJOR_OP_HI = 4'h4;
  // Register-format function codes
  localparam logic [5:0] FN_SUM_WITH_TRAP = 6'h20;
  localparam logic [5:0] FN_SUM_NO_TRAP = 6'h21;
  localparam logic [5:0] FN_AND = 6'h24;
  localparam logic [5:0] FN_JUMP_REG = 6'h08;
  localparam logic [5:0] FN_JUMP_REG_LINK = 6'h09;
  // Coprocessor branch fields
  localparam logic [4:0] COP_BRANCH_SUBOP = 5'h08;
  localparam logic [4:0] COND_FALSE_CODE = 5'h00;
  localparam logic [4:0] COND_FALSE_LIKELY_CODE = 5'h02;
  // Exception codes
  localparam logic [4:0] EXC_INTERRUPT = 5'h00;
  localparam logic [4:0] EXC_ADDR_ERROR = 5'h04;
  localparam logic [4:0] EXC_COP_UNUSABLE = 5'h0b;
  localparam logic [4:0] EXC_OVERFLOW = 5'h0c;
  // Address steps
  localparam logic [31:0] PC_STEP = 32'h4;
  localparam logic [31:0] LINK_STEP = 32'h8;

  // Delay-slot tracking, one-hot
  typedef enum logic [2:0] {
    MODE_SEQ = 3'b001,
    MODE_SLOT = 3'b010,
    MODE_NULLIFY = 3'b100
  } bdal_mode_t;

  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [31:0] word;
  } bdal_fetch_t;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [31:0] data;
  } bdal_wb_t;

  typedef struct packed {
    logic valid;
    logic [4:0] code;
    logic [1:0] unit;
    logic [31:0] bad_addr;
  } bdal_exc_t;

  typedef struct packed {
    bdal_mode_t mode;
    logic taken;
    logic target_bad;
    logic [31:0] target;
    logic [31:0] branch_pc;
    logic [3:0] cond_prev;
    logic [31:0] exception_return_pc;
    bdal_wb_t wb;
    bdal_exc_t exc;
    logic redir;
    logic [31:0] redir_pc;
  } bdal_state_t;

  localparam bdal_state_t STATE_RESET = '{mode: MODE_SEQ, default: '0};
endpackage
`default_nettype wire

// File: hdl/bdal_exec.sv
/*
  Execute block for jumps through a register, coprocessor branch-on-false
  (plain and likely), the four add forms and the two AND forms, with the
  one-instruction delay slot and restart of a faulting delay slot.
  Assumes the fetch path presents one instruction per cycle in program order
  and obeys REDIRECT_O, and that the register file answers reads in-cycle.
*/
// Contract
// - Jumps and branches take effect after the following delay-slot instruction.
// - A faulting delay slot loads the return pc with the branch address.
// - Return from exception re-executes the branch and then its delay slot.
// - Register jumps to a misaligned address raise address error at target fetch.
// - Trapping register add writes the sum, or traps on overflow without writing.
// - Trapping immediate add sign-extends, adds, traps on overflow without writing.
// - Non-trapping immediate add sign-extends, writes the sum, never traps.
// - Non-trapping register add writes the sum and never traps.
// - Register AND writes the bitwise AND, no exception.
// - Immediate AND zero-extends the immediate; upper result half is zero.
// - Coprocessor branch target is delay-slot address plus shifted sign-extended offset.
// - Coprocessor branches use the condition captured during the previous instruction.
// - Branch-on-false decodes 0100xx, 01000, 00000 and branches when condition false.
// - Likely form branches when false and nullifies the delay slot when true.
// - Both forms raise coprocessor-unusable when the selected unit is unusable.
`default_nettype none
module bdal_exec (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire bdal_pkg::bdal_fetch_t FETCH_I,
  input wire logic [31:0] SRC_A_DATA_I,
  input wire logic [31:0] SRC_B_DATA_I,
  input wire logic [3:0] COP_CONDITION_IN_I,
  input wire logic [3:0] COP_USABLE_I,
  input wire logic INTERRUPT_I,
  input wire logic RETURN_I,
  output logic [4:0] SRC_REG_A_O,
  output logic [4:0] SRC_REG_B_O,
  output bdal_pkg::bdal_wb_t WB_O,
  output bdal_pkg::bdal_exc_t EXC_O,
  output logic [31:0] EXCEPTION_RETURN_PC_O,
  output logic REDIRECT_O,
  output logic [31:0] REDIRECT_PC_O
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_b;
  logic rst_b;

  // Asynchronous assert, synchronous release
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta_b <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_b <= rst_meta_b;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  bdal_pkg::bdal_state_t s;
  bdal_pkg::bdal_state_t next_s;
  logic [31:0] w;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] imm_sx;
  logic [32:0] sum_rr;
  logic [32:0] sum_ri;
  logic is_reg;
  logic is_sum_trap;
  logic is_sum_no_trap;
  logic is_and;
  logic is_jump_reg;
  logic is_jump_link;
  logic is_sum_imm_trap;
  logic is_sum_imm_no_trap;
  logic is_mask_imm;
  logic is_cop_branch;
  logic is_cop_false;
  logic is_cop_false_likely;
  logic cop_cond;
  logic live;
  logic ovf_trap;
  logic cop_fault;
  logic exc_now;

  assign w = FETCH_I.word;
  assign a = SRC_A_DATA_I;
  assign b = SRC_B_DATA_I;
  // Register read addresses go straight from the word
  assign SRC_REG_A_O = w[25:21];
  assign SRC_REG_B_O = w[20:16];
  assign imm_sx = {{16{w[15]}}, w[15:0]};
  // Extra top bit exposes the carry out of bit 31 against bit 30
  assign sum_rr = {a[31], a} + {b[31], b};
  assign sum_ri = {a[31], a} + {imm_sx[31], imm_sx};

  // Shift field must be zero, otherwise the word is not ours
  assign is_reg = (w[31:26] == bdal_pkg::REG_FORMAT_MAJOR_OP) && (w[10:6] == 5'h00);
  assign is_sum_trap = is_reg && (w[5:0] == bdal_pkg::FN_SUM_WITH_TRAP);
  assign is_sum_no_trap = is_reg && (w[5:0] == bdal_pkg::FN_SUM_NO_TRAP);
  assign is_and = is_reg && (w[5:0] == bdal_pkg::FN_AND);
  assign is_jump_reg = is_reg && (w[5:0] == bdal_pkg::FN_JUMP_REG);
  assign is_jump_link = is_reg && (w[5:0] == bdal_pkg::FN_JUMP_REG_LINK);
  assign is_sum_imm_trap = (w[31:26] == bdal_pkg::OP_SUM_IMM_WITH_TRAP);
  assign is_sum_imm_no_trap = (w[31:26] == bdal_pkg::OP_SUM_IMM_NO_TRAP);
  assign is_mask_imm = (w[31:26] == bdal_pkg::OP_MASK_WITH_IMM);
  assign is_cop_branch = (w[31:28] == bdal_pkg::COP_MAJOR_OP_HI) && (w[25:21] == bdal_pkg::COP_BRANCH_SUBOP);
  assign is_cop_false = is_cop_branch && (w[20:16] == bdal_pkg::COND_FALSE_CODE);
  assign is_cop_false_likely = is_cop_branch && (w[20:16] == bdal_pkg::COND_FALSE_LIKELY_CODE);
  // Condition as seen during the instruction before this one
  assign cop_cond = s.cond_prev[w[27:26]];

  // An instruction that executes (not a nullified slot, not beaten by a return)
  assign live = FETCH_I.valid && !RETURN_I && (s.mode != bdal_pkg::MODE_NULLIFY);
  assign ovf_trap = (is_sum_trap && (sum_rr[32] != sum_rr[31]))
    || (is_sum_imm_trap && (sum_ri[32] != sum_ri[31]));
  assign cop_fault = (is_cop_false || is_cop_false_likely) && !COP_USABLE_I[w[27:26]];
  assign exc_now = live && (INTERRUPT_I || ovf_trap || cop_fault);

  // ****************************************
  // Next state
  // ****************************************
  // Branch outcome is held one instruction, so a redirect issues only when
  // the delay slot completes; a fault in the slot drops the pending branch.
  always_comb begin
    next_s = s;
    next_s.wb.en = 1'b0;
    next_s.exc.valid = 1'b0;
    next_s.redir = 1'b0;
    if (RETURN_I) begin
      // Restart at the saved pc; a saved branch runs again before its slot
      next_s.redir = 1'b1;
      next_s.redir_pc = s.exception_return_pc;
      next_s.mode = bdal_pkg::MODE_SEQ;
      next_s.taken = 1'b0;
      next_s.target_bad = 1'b0;
    end else if (FETCH_I.valid) begin
      next_s.cond_prev = COP_CONDITION_IN_I;
      if (s.mode == bdal_pkg::MODE_NULLIFY) begin
        // Silent slot, fetch simply carries on
        next_s.mode = bdal_pkg::MODE_SEQ;
      end else if (exc_now) begin
        next_s.exc.valid = 1'b1;
        next_s.exc.unit = w[27:26];
        next_s.exc.bad_addr = 32'h0;
        next_s.exc.code = INTERRUPT_I ? bdal_pkg::EXC_INTERRUPT :
          cop_fault ? bdal_pkg::EXC_COP_UNUSABLE : bdal_pkg::EXC_OVERFLOW;
        // In a delay slot point back at the branch so that both are executed again, otherwise at this instruction
        next_s.exception_return_pc = (s.mode == bdal_pkg::MODE_SLOT) ? s.branch_pc : FETCH_I.pc;
        next_s.mode = bdal_pkg::MODE_SEQ;
      end else begin
        next_s.wb.addr = w[15:11];
        if (is_sum_trap || is_sum_no_trap) begin
          next_s.wb.en = 1'b1;
          next_s.wb.data = sum_rr[31:0];
        end else if (is_and) begin
          next_s.wb.en = 1'b1;
          next_s.wb.data = a & b;
        end else if (is_sum_imm_trap || is_sum_imm_no_trap) begin
          next_s.wb.en = 1'b1;
          next_s.wb.addr = w[20:16];
          next_s.wb.data = sum_ri[31:0];
        end else if (is_mask_imm) begin
          next_s.wb.en = 1'b1;
          next_s.wb.addr = w[20:16];
          next_s.wb.data = {16'h0000, a[15:0] & w[15:0]};
        end else if (is_jump_link) begin
          next_s.wb.en = 1'b1;
          next_s.wb.data = FETCH_I.pc + bdal_pkg::LINK_STEP;
        end
        if (s.mode == bdal_pkg::MODE_SLOT) begin
          next_s.mode = bdal_pkg::MODE_SEQ;
          if (s.target_bad) begin
            // Fault belongs to the target fetch, so the target is saved
            next_s.exc.valid = 1'b1;
            next_s.exc.code = bdal_pkg::EXC_ADDR_ERROR;
            next_s.exc.bad_addr = s.target;
            next_s.exception_return_pc = s.target;
          end else if (s.taken) begin
            next_s.redir = 1'b1;
            next_s.redir_pc = s.target;
          end
        end else if (is_jump_reg || is_jump_link) begin
          next_s.mode = bdal_pkg::MODE_SLOT;
          next_s.branch_pc = FETCH_I.pc;
          next_s.taken = 1'b1;
          next_s.target = a;
          next_s.target_bad = (a[1:0] != 2'b00);
        end else if (is_cop_false || is_cop_false_likely) begin
          next_s.branch_pc = FETCH_I.pc;
          next_s.taken = !cop_cond;
          next_s.target_bad = 1'b0;
          next_s.target = FETCH_I.pc + bdal_pkg::PC_STEP + {{14{w[15]}}, w[15:0], 2'b00};
          // Likely and true: the slot becomes a no-operation
          next_s.mode = (is_cop_false_likely && cop_cond) ? bdal_pkg::MODE_NULLIFY : bdal_pkg::MODE_SLOT;
        end
      end
    end
  end

  // ****************************************
  // State register and outputs
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge rst_b) begin
    if (!rst_b) begin
      s <= bdal_pkg::STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign WB_O = s.wb;
  assign EXC_O = s.exc;
  assign EXCEPTION_RETURN_PC_O = s.exception_return_pc;
  assign REDIRECT_O = s.redir;
  assign REDIRECT_PC_O = s.redir_pc;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!rst_b);

  a_slot_redirect: assert property (
    (FETCH_I.valid && !RETURN_I && s.mode == bdal_pkg::MODE_SLOT && s.taken && !s.target_bad && !exc_now)
    |=> (REDIRECT_O && REDIRECT_PC_O == $past(s.target))) else $error("Taken branch did not redirect after slot");
  a_slot_epc: assert property (
    (exc_now && s.mode == bdal_pkg::MODE_SLOT)
    |=> (EXC_O.valid && EXCEPTION_RETURN_PC_O == $past(s.branch_pc))) else $error("Slot fault saved wrong pc");
  a_return_restart: assert property (
    RETURN_I |=> (REDIRECT_O && REDIRECT_PC_O == $past(s.exception_return_pc) && s.mode == bdal_pkg::MODE_SEQ))
    else $error("Return did not restart at saved pc");
  a_jump_align: assert property (
    (live && !exc_now && s.mode == bdal_pkg::MODE_SEQ && is_jump_reg && a[1:0] != 2'b00)
    ##1 (FETCH_I.valid && !RETURN_I && !exc_now)
    |=> (EXC_O.valid && EXC_O.code == bdal_pkg::EXC_ADDR_ERROR && !REDIRECT_O))
    else $error("Misaligned jump target not faulted");
  a_ovf_no_write: assert property (
    (live && !INTERRUPT_I && !cop_fault && ovf_trap)
    |=> (EXC_O.valid && EXC_O.code == bdal_pkg::EXC_OVERFLOW && !WB_O.en)) else $error("Overflow wrote or missed trap");
  // A slot behind a misaligned jump still writes but also reports the address error
  a_sum_no_trap: assert property (
    (live && !INTERRUPT_I && is_sum_no_trap && !(s.mode == bdal_pkg::MODE_SLOT && s.target_bad))
    |=> (WB_O.en && !EXC_O.valid && WB_O.data == $past(a) + $past(b))) else $error("Plain add result wrong");
  a_mask_upper: assert property (
    (live && !INTERRUPT_I && is_mask_imm) |=> (WB_O.en && WB_O.data[31:16] == 16'h0000))
    else $error("Immediate AND upper half not zero");
  a_null_silent: assert property (
    (FETCH_I.valid && !RETURN_I && s.mode == bdal_pkg::MODE_NULLIFY)
    |=> (!WB_O.en && !EXC_O.valid && !REDIRECT_O)) else $error("Nullified slot had an effect");
  a_likely_null: assert property (
    (live && !exc_now && s.mode == bdal_pkg::MODE_SEQ && is_cop_false_likely && cop_cond)
    |=> (s.mode == bdal_pkg::MODE_NULLIFY)) else $error("Likely branch did not nullify slot");
  a_cop_unusable: assert property (
    (live && !INTERRUPT_I && cop_fault)
    |=> (EXC_O.valid && EXC_O.code == bdal_pkg::EXC_COP_UNUSABLE)) else $error("Unusable unit not trapped");
endmodule
`default_nettype wire

// File: bench/bdal_regfile_model.sv
/*
  Register file model facing the execute block: two same-cycle reads and
  one write port fed from the block's writeback.
  Assumes writes land on the rising clock edge and that the bench preloads
  every operand it uses before the first instruction.
*/
`default_nettype none
module bdal_regfile_model (
  input wire logic clk_i,
  input wire logic [4:0] rd_a_i,
  input wire logic [4:0] rd_b_i,
  input wire bdal_pkg::bdal_wb_t wb_i,
  output logic [31:0] data_a_o,
  output logic [31:0] data_b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************
  // Storage and ports
  // ************************
  logic [31:0] regs [32];

  // Preload hook for the bench; no real port, so no write conflict
  task automatic put(input logic [4:0] idx, input logic [31:0] val);
    regs[idx] = val;
  endtask

  // Register 0 reads as zero, so the writes it gets are stored but never seen
  assign data_a_o = (rd_a_i == 5'h00) ? 32'h0 : regs[rd_a_i];
  assign data_b_o = (rd_b_i == 5'h00) ? 32'h0 : regs[rd_b_i];

  // Writeback port
  always @(posedge clk_i) begin
    if (wb_i.en) begin
      regs[wb_i.addr] <= wb_i.data;
    end
  end
endmodule
`default_nettype wire

// File: bench/bdal_exec_bench.sv
/*
  Self-checking bench for the execute block: adds, ANDs, register jumps,
  coprocessor branch-on-false forms, delay-slot interrupt and return.
  Assumes the block answers one cycle after an instruction is taken.
*/
`default_nettype none
`define CHK(nm, ex, got) \
  begin n_compared++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module bdal_exec_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************
  // Signals and instances
  // ************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  bdal_pkg::bdal_fetch_t fetch = '0;
  logic [3:0] cond = 4'h0;
  logic [3:0] usable = 4'hf;
  logic irq = 1'b0;
  logic ret = 1'b0;
  logic [31:0] a_data, b_data, exception_return_pc, rpc;
  logic [4:0] ra, rb;
  logic redir;
  bdal_pkg::bdal_wb_t wb;
  bdal_pkg::bdal_exc_t exc;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  bdal_exec dut_u (.CLOCK_I(clk), .RST_B_I(rst_b), .FETCH_I(fetch), .SRC_A_DATA_I(a_data),
    .SRC_B_DATA_I(b_data), .COP_CONDITION_IN_I(cond), .COP_USABLE_I(usable), .INTERRUPT_I(irq),
    .RETURN_I(ret), .SRC_REG_A_O(ra), .SRC_REG_B_O(rb), .WB_O(wb), .EXC_O(exc),
    .EXCEPTION_RETURN_PC_O(exception_return_pc), .REDIRECT_O(redir), .REDIRECT_PC_O(rpc));
  bdal_regfile_model model_u (.clk_i(clk), .rd_a_i(ra), .rd_b_i(rb), .wb_i(wb),
    .data_a_o(a_data), .data_b_o(b_data));

  // ************************
  // Helpers
  // ************************
  function automatic logic [31:0] rf(input logic [4:0] s, t, d, input logic [5:0] fn);
    return {bdal_pkg::REG_FORMAT_MAJOR_OP, s, t, d, 5'h00, fn};
  endfunction
  function automatic logic [31:0] cb(input logic [1:0] z, input logic [4:0] code);
    return {bdal_pkg::COP_MAJOR_OP_HI, z, bdal_pkg::COP_BRANCH_SUBOP, code, 16'hfffe};
  endfunction

  // Present one instruction at the falling edge; return after it is taken
  task automatic exec(input logic [31:0] w, pc, input logic [3:0] c, input logic i);
    fetch = '{valid: 1'b1, pc: pc, word: w};
    cond = c;
    irq = i;
    @(posedge clk);
    @(negedge clk);
  endtask

  // Idle cycle; fetch must not run on past a redirect
  task automatic gap();
    fetch.valid = 1'b0;
    irq = 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic ck(input logic we, input logic [31:0] d, input logic ev, input logic [4:0] code);
    `CHK("wb_en", we, wb.en)
    if (we) `CHK("wb_data", d, wb.data)
    `CHK("exc_valid", ev, exc.valid)
    if (ev) `CHK("exc_code", code, exc.code)
  endtask

  // ************************
  // Scenarios
  // ************************
  // Overflow boundary 0x7fffffff + 1 on every add form
  task automatic t_adds();
    exec(rf(1, 2, 10, bdal_pkg::FN_SUM_NO_TRAP), 32'h100, 4'h0, 1'b0);
    ck(1'b1, 32'h80000000, 1'b0, 5'h00);
    `CHK("wb_addr", 5'd10, wb.addr)
    exec(rf(1, 2, 11, bdal_pkg::FN_SUM_WITH_TRAP), 32'h104, 4'h0, 1'b0);
    ck(1'b0, 32'h0, 1'b1, bdal_pkg::EXC_OVERFLOW);
    exec(rf(6, 2, 11, bdal_pkg::FN_SUM_WITH_TRAP), 32'h108, 4'h0, 1'b0);
    ck(1'b1, 32'h6, 1'b0, 5'h00);
    exec({6'h08, 5'd1, 5'd12, 16'h0001}, 32'h10c, 4'h0, 1'b0);
    ck(1'b0, 32'h0, 1'b1, bdal_pkg::EXC_OVERFLOW);
    exec({6'h08, 5'd6, 5'd12, 16'hfffe}, 32'h110, 4'h0, 1'b0);
    ck(1'b1, 32'h3, 1'b0, 5'h00);
    exec({6'h09, 5'd1, 5'd13, 16'h0001}, 32'h114, 4'h0, 1'b0);
    ck(1'b1, 32'h80000000, 1'b0, 5'h00);
    exec(rf(1, 2, 14, bdal_pkg::FN_SUM_NO_TRAP) | 32'h40, 32'h118, 4'h0, 1'b0);
    ck(1'b0, 32'h0, 1'b0, 5'h00);
    exec(rf(4, 5, 15, bdal_pkg::FN_AND), 32'h11c, 4'h0, 1'b0);
    ck(1'b1, 32'h0f0f1234, 1'b0, 5'h00);
    exec({6'h0c, 5'd4, 5'd16, 16'h8001}, 32'h120, 4'h0, 1'b0);
    ck(1'b1, 32'h00008001, 1'b0, 5'h00);
    gap();
  endtask

  // Misaligned jump faults at target fetch; aligned link jump redirects
  task automatic t_jr();
    exec(rf(7, 0, 0, bdal_pkg::FN_JUMP_REG), 32'h200, 4'h0, 1'b0);
    exec(rf(6, 2, 22, bdal_pkg::FN_SUM_NO_TRAP), 32'h204, 4'h0, 1'b0);
    ck(1'b1, 32'h6, 1'b1, bdal_pkg::EXC_ADDR_ERROR);
    `CHK("bad_addr", 32'h1001, exc.bad_addr)
    `CHK("ae_epc", 32'h1001, exception_return_pc)
    gap();
    exec(rf(8, 0, 23, bdal_pkg::FN_JUMP_REG_LINK), 32'h208, 4'h0, 1'b0);
    `CHK("early_redir", 1'b0, redir)
    exec(rf(6, 2, 22, bdal_pkg::FN_SUM_NO_TRAP), 32'h20c, 4'h0, 1'b0);
    `CHK("redir", 1'b1, redir)
    `CHK("redir_pc", 32'h2000, rpc)
    gap();
  endtask

  // Every unit, both forms, both conditions; condition flips at the branch
  task automatic t_cop();
    logic [3:0] cv;
    for (int z = 0; z < 4; z++) begin
      for (int lk = 0; lk < 2; lk++) begin
        for (int c = 0; c < 2; c++) begin
          cv = 4'(c) << z;
          exec(rf(0, 0, 0, bdal_pkg::FN_SUM_NO_TRAP), 32'hffc, cv, 1'b0);
          exec(cb(2'(z), lk ? bdal_pkg::COND_FALSE_LIKELY_CODE : bdal_pkg::COND_FALSE_CODE),
            32'h1000, ~cv, 1'b0);
          exec(rf(6, 2, 20, bdal_pkg::FN_SUM_NO_TRAP), 32'h1004, ~cv, 1'b0);
          `CHK("redir", c == 0, redir)
          `CHK("slot_wb", !(lk && c), wb.en)
          if (c == 0) `CHK("target", 32'h1004 + {{14{1'b1}}, 16'hfffe, 2'b00}, rpc)
          gap();
        end
      end
    end
    usable = 4'hb;
    for (int lk = 0; lk < 2; lk++) begin
      exec(cb(2'h2, lk ? bdal_pkg::COND_FALSE_LIKELY_CODE : bdal_pkg::COND_FALSE_CODE),
        32'h1100, 4'h0, 1'b0);
      ck(1'b0, 32'h0, 1'b1, bdal_pkg::EXC_COP_UNUSABLE);
      `CHK("exc_unit", 2'h2, exc.unit)
      gap();
    end
    usable = 4'hf;
  endtask

  // Interrupted delay slot, return, then branch and slot run again
  task automatic t_irq();
    exec(rf(0, 0, 0, bdal_pkg::FN_SUM_NO_TRAP), 32'h2fc, 4'h0, 1'b0);
    exec(cb(2'h1, bdal_pkg::COND_FALSE_CODE), 32'h300, 4'h0, 1'b0);
    exec(rf(6, 2, 21, bdal_pkg::FN_SUM_NO_TRAP), 32'h304, 4'h0, 1'b1);
    ck(1'b0, 32'h0, 1'b1, bdal_pkg::EXC_INTERRUPT);
    `CHK("epc", 32'h300, exception_return_pc)
    `CHK("no_redir", 1'b0, redir)
    gap();
    ret = 1'b1;
    @(posedge clk);
    @(negedge clk);
    ret = 1'b0;
    `CHK("ret_redir", 1'b1, redir)
    `CHK("ret_pc", 32'h300, rpc)
    exec(cb(2'h1, bdal_pkg::COND_FALSE_CODE), 32'h300, 4'h0, 1'b0);
    exec(rf(6, 2, 21, bdal_pkg::FN_SUM_NO_TRAP), 32'h304, 4'h0, 1'b0);
    ck(1'b1, 32'h6, 1'b0, 5'h00);
    `CHK("rerun_redir", 1'b1, redir)
    `CHK("rerun_pc", 32'h2fc, rpc)
    gap();
  endtask

  // ************************
  // Run control
  // ************************
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run is about a hundred cycles; the ceiling only catches hangs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    model_u.put(5'd1, 32'h7fffffff);
    model_u.put(5'd2, 32'h00000001);
    model_u.put(5'd4, 32'hffffffff);
    model_u.put(5'd5, 32'h0f0f1234);
    model_u.put(5'd6, 32'h00000005);
    model_u.put(5'd7, 32'h00001001);
    model_u.put(5'd8, 32'h00002000);
    t_adds();
    t_jr();
    t_cop();
    t_irq();
    finish_test();
  end
endmodule
`default_nettype wire
